/* File: design/bmam_pkg.sv */
package bmam_pkg;
    // program side
    localparam int PC_W = 13;
    localparam int PROG_SPACE_WORDS = 8192;
    localparam int INSTR_W = 14;
    localparam int PROG_AW_2K = 11;
    localparam int PROG_AW_4K = 12;
    localparam int LIT_W = 11;
    localparam int LATCH_W = 5;
    localparam logic [12:0] PC_RESET_VEC = 13'h0000;
    localparam logic [12:0] PC_IRQ_VEC = 13'h0004;
    localparam logic [12:0] PC_STEP = 13'h0001;

    // instruction cycle timing
    localparam int CLK_MHZ = 20;
    localparam int ICYC_NS = 200;
    localparam int CLKS_PER_ICYC = (ICYC_NS * CLK_MHZ + 999) / 1000;
    localparam int PH_W = 2;
    localparam logic [1:0] PH_LAST = 2'(CLKS_PER_ICYC - 1);
    localparam logic [1:0] PH_STEP = 2'h1;

    // data side
    localparam int DAT_W = 8;
    localparam int OFF_W = 7;
    localparam int DAT_AW = 9;
    localparam int RAM_AW = 8;
    localparam int RAM_DEPTH = 256;
    localparam logic [6:0] OFF_INDIRECT = 7'h00;
    localparam logic [6:0] OFF_PCL = 7'h02;
    localparam logic [6:0] OFF_STATUS = 7'h03;
    localparam logic [6:0] OFF_POINTER = 7'h04;
    localparam logic [6:0] OFF_PCLATCH = 7'h0A;
    localparam logic [6:0] OFF_INTCTL = 7'h0B;
    localparam logic [6:0] OFF_GPR_LO = 7'h20;
    localparam logic [6:0] OFF_COMMON_LO = 7'h70;
    localparam logic [1:0] BANK0 = 2'h0;
    localparam logic [1:0] BANK1 = 2'h1;
    localparam logic [1:0] BANK2 = 2'h2;
    localparam logic [7:0] RAM_BASE_B0 = 8'h00;
    localparam logic [7:0] RAM_BASE_B1 = 8'h60;
    localparam logic [7:0] RAM_BASE_B2 = 8'hB0;

    // status byte layout
    localparam int ST_INDIRECT_BANK_SELECT = 7;
    localparam int ST_BANK_SELECT_HIGH = 6;
    localparam int ST_BANK_SELECT_LOW = 5;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [4:0] PCLATCH_RST = 5'h00;

    // return stack
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PW = 3;
    localparam logic [2:0] STACK_STEP = 3'h1;

    typedef enum logic [1:0] {
        BMAM_PC_SEQ,
        BMAM_PC_GOTO,
        BMAM_PC_CALL,
        BMAM_PC_RET
    } bmam_pcop_t;
endpackage

/* File: design/bmam_gpr_ram.sv */
`timescale 1ns/1ps
module bmam_gpr_ram (
    input wire logic mclk_in,
    input wire logic we_in,
    input wire logic [bmam_pkg::RAM_AW-1:0] addr_in,
    input wire logic [bmam_pkg::DAT_W-1:0] wdata_in,
    output logic [bmam_pkg::DAT_W-1:0] rdata_out
);
    logic [bmam_pkg::DAT_W-1:0] mem_r [bmam_pkg::RAM_DEPTH];
    logic [bmam_pkg::DAT_W-1:0] q_r;

    // contents are undefined after reset, like any static ram
    always_ff @(posedge mclk_in)
    begin
        if (we_in)
        begin
            mem_r[addr_in] <= wdata_in;
        end
        q_r <= mem_r[addr_in];
    end

    assign rdata_out = q_r;
endmodule // bmam_gpr_ram

/* File: design/bmam_ret_stack.sv */
`timescale 1ns/1ps
module bmam_ret_stack (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [bmam_pkg::PC_W-1:0] push_data_in,
    output logic [bmam_pkg::PC_W-1:0] top_out
);
    logic [bmam_pkg::PC_W-1:0] ent_r [bmam_pkg::STACK_DEPTH];
    logic [bmam_pkg::STACK_PW-1:0] ptr_r;
    logic [bmam_pkg::STACK_PW-1:0] top_idx_w;

    assign top_idx_w = ptr_r - bmam_pkg::STACK_STEP;
    assign top_out = ent_r[top_idx_w];

    // pointer wraps
    // ninth push silently lands on the oldest entry, no overflow flag
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            ptr_r <= '0;
        end
        else if (push_in)
        begin
            ent_r[ptr_r] <= push_data_in;
            ptr_r <= ptr_r + bmam_pkg::STACK_STEP;
        end
        else if (pop_in)
        begin
            ptr_r <= top_idx_w;
        end
    end

    AST_STACK_PUSH_TOP: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        push_in |=> top_out == $past(push_data_in))
        else $error("pushed return address not on top of stack");
endmodule // bmam_ret_stack

/* File: design/bmam_top.sv */
// Summary of operation
// - 13-bit program counter spans 8K words of 14 bits.
// - implemented program store is a 2K or 4K word parameter.
// - fetches above the implemented store wrap onto implemented words.
// - reset loads address 0000h; taken interrupt continues at 0004h.
// - status bits 6:5 pick data bank 0 to 3.
// - each bank holds 128 byte offsets up to 7Fh.
// - special registers at low offsets, general ram above them.
// - every bank has special registers; all are mirrored across banks.
// - data reachable by direct address or through the indirect pointer.
// - program and data buses are separate and work concurrently.
// - one instruction cycle per instruction, branches take two.
// - eight-deep hardware return stack for calls and interrupts.
// - unimplemented data locations read as zero.
// - indirect location redirects via pointer and holds no register.
// - status, pointer, pc low, latch and interrupt control in all banks.
// - pc bits 12:8 load from the 5-bit latch on pc writes.
`timescale 1ns/1ps
module bmam_top #(
    parameter int PROG_AW = bmam_pkg::PROG_AW_2K
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [bmam_pkg::INSTR_W-1:0] prog_word_in,
    input wire bmam_pkg::bmam_pcop_t pc_op_in,
    input wire logic [bmam_pkg::LIT_W-1:0] pc_lit_in,
    input wire logic irq_take_in,
    input wire logic [bmam_pkg::OFF_W-1:0] dat_addr_in,
    input wire logic dat_rd_in,
    input wire logic dat_wr_in,
    input wire logic [bmam_pkg::DAT_W-1:0] dat_wdata_in,
    output logic [PROG_AW-1:0] prog_addr_out,
    output logic [bmam_pkg::PC_W-1:0] pc_out,
    output logic [bmam_pkg::INSTR_W-1:0] instr_out,
    output logic instr_flush_out,
    output logic cyc_end_out,
    output logic [bmam_pkg::DAT_W-1:0] dat_rdata_out,
    output logic dat_rvalid_out,
    output logic [bmam_pkg::DAT_W-1:0] status_out,
    output logic [bmam_pkg::DAT_W-1:0] intctl_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    // instruction cycle phase
    logic [bmam_pkg::PH_W-1:0] ph_r;
    logic [bmam_pkg::PH_W-1:0] ph_nxt;
    logic cyc_end_r;

    // program counter state
    logic [bmam_pkg::PC_W-1:0] pc_r;
    logic [bmam_pkg::PC_W-1:0] pc_nxt;
    logic [PROG_AW-1:0] prog_addr_r;
    logic [bmam_pkg::INSTR_W-1:0] instr_r;
    logic flush_r;
    logic branch_w;
    logic push_w;
    logic pop_w;
    logic [bmam_pkg::PC_W-1:0] stk_top_w;
    logic [bmam_pkg::PC_W-1:0] jump_tgt_w;

    // core registers, mirrored in every bank
    logic [bmam_pkg::DAT_W-1:0] status_r;
    logic [bmam_pkg::DAT_W-1:0] indirect_address_pointer_r;
    logic [bmam_pkg::LATCH_W-1:0] pc_upper_latch_r;
    logic [bmam_pkg::DAT_W-1:0] intctl_r;
    logic pcl_pend_r;
    logic [bmam_pkg::DAT_W-1:0] pcl_pend_val_r;

    // data address decode
    logic ind_w;
    logic [bmam_pkg::DAT_AW-1:0] eff_addr_w;
    logic [bmam_pkg::OFF_W-1:0] eff_off_w;
    logic sel_pcl_w;
    logic sel_status_w;
    logic sel_pointer_w;
    logic sel_latch_w;
    logic sel_intctl_w;
    logic ram_hit_w;
    logic [bmam_pkg::RAM_AW-1:0] ram_idx_w;
    logic [bmam_pkg::DAT_W-1:0] sfr_val_w;
    logic [bmam_pkg::DAT_W-1:0] ram_q_w;
    logic pcl_wr_w;
    logic pcl_go_w;
    logic [bmam_pkg::DAT_W-1:0] pcl_low_w;

    // read pipeline
    logic rd1_r;
    logic ram_sel1_r;
    logic [bmam_pkg::DAT_W-1:0] sfr1_r;
    logic [bmam_pkg::DAT_W-1:0] rdata_r;
    logic rvalid_r;

    // maps a bank address onto the shared ram; top bit is the hit flag
    function automatic logic [8:0] ram_map(input logic [8:0] addr);
        logic [6:0] off;
        logic [7:0] rel;
        off = addr[6:0];
        rel = {1'b0, off} - {1'b0, bmam_pkg::OFF_GPR_LO};
        ram_map = '0;
        if (off >= bmam_pkg::OFF_COMMON_LO)
        begin
            ram_map = {1'b1, rel + bmam_pkg::RAM_BASE_B0};
        end
        else if (off >= bmam_pkg::OFF_GPR_LO)
        begin
            case (addr[8:7])
                bmam_pkg::BANK0: ram_map = {1'b1, rel + bmam_pkg::RAM_BASE_B0};
                bmam_pkg::BANK1: ram_map = {1'b1, rel + bmam_pkg::RAM_BASE_B1};
                bmam_pkg::BANK2: ram_map = {1'b1, rel + bmam_pkg::RAM_BASE_B2};
                default: ram_map = '0;
            endcase
        end
    endfunction

    assign ph_nxt = ph_r + bmam_pkg::PH_STEP;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            ph_r <= '0;
            cyc_end_r <= 1'b0;
        end
        else
        begin
            ph_r <= ph_nxt;
            cyc_end_r <= (ph_nxt == bmam_pkg::PH_LAST);
        end
    end

    assign ind_w = (dat_addr_in == bmam_pkg::OFF_INDIRECT);
    assign eff_addr_w = ind_w
        ? {status_r[bmam_pkg::ST_INDIRECT_BANK_SELECT],
           indirect_address_pointer_r}
        : {status_r[bmam_pkg::ST_BANK_SELECT_HIGH:
                    bmam_pkg::ST_BANK_SELECT_LOW], dat_addr_in};
    assign eff_off_w = eff_addr_w[bmam_pkg::OFF_W-1:0];

    assign sel_pcl_w = (eff_off_w == bmam_pkg::OFF_PCL);
    assign sel_status_w = (eff_off_w == bmam_pkg::OFF_STATUS);
    assign sel_pointer_w = (eff_off_w == bmam_pkg::OFF_POINTER);
    assign sel_latch_w = (eff_off_w == bmam_pkg::OFF_PCLATCH);
    assign sel_intctl_w = (eff_off_w == bmam_pkg::OFF_INTCTL);

    assign {ram_hit_w, ram_idx_w} = ram_map(eff_addr_w);

    assign sfr_val_w = sel_pcl_w ? pc_r[bmam_pkg::DAT_W-1:0]
        : sel_status_w ? status_r
        : sel_pointer_w ? indirect_address_pointer_r
        : sel_latch_w ? {3'h0, pc_upper_latch_r}
        : sel_intctl_w ? intctl_r
        : 8'h00;

    bmam_gpr_ram u_ram (
        .mclk_in(mclk_in),
        .we_in(dat_wr_in & ram_hit_w),
        .addr_in(ram_idx_w),
        .wdata_in(dat_wdata_in),
        .rdata_out(ram_q_w)
    );

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            rd1_r <= 1'b0;
            ram_sel1_r <= 1'b0;
            sfr1_r <= '0;
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rd1_r <= dat_rd_in;
            ram_sel1_r <= ram_hit_w;
            sfr1_r <= sfr_val_w;
            rdata_r <= ram_sel1_r ? ram_q_w : sfr1_r;
            rvalid_r <= rd1_r;
        end
    end

    // core register writes; pc low is handled with the pc
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            status_r <= bmam_pkg::STATUS_RST;
            indirect_address_pointer_r <= bmam_pkg::POINTER_RST;
            pc_upper_latch_r <= bmam_pkg::PCLATCH_RST;
            intctl_r <= bmam_pkg::INTCTL_RST;
        end
        else if (dat_wr_in)
        begin
            if (sel_status_w)
                status_r <= dat_wdata_in;
            if (sel_pointer_w)
                indirect_address_pointer_r <= dat_wdata_in;
            if (sel_latch_w)
                pc_upper_latch_r <= dat_wdata_in[bmam_pkg::LATCH_W-1:0];
            if (sel_intctl_w)
                intctl_r <= dat_wdata_in;
        end
    end

    // a pc low write mid-cycle waits for the cycle end; a new write wins
    assign pcl_wr_w = dat_wr_in & sel_pcl_w;
    assign pcl_go_w = pcl_wr_w | pcl_pend_r;
    assign pcl_low_w = pcl_wr_w ? dat_wdata_in : pcl_pend_val_r;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            pcl_pend_r <= 1'b0;
            pcl_pend_val_r <= '0;
        end
        else
        begin
            // a write on the cycle-end edge is consumed there, but stays armed if an interrupt is taken on that edge
            pcl_pend_r <= (pcl_wr_w | pcl_pend_r)
                & ~(cyc_end_r & ~irq_take_in);
            if (pcl_wr_w)
                pcl_pend_val_r <= dat_wdata_in;
        end
    end

    // call and goto keep latch bits 4:3 above the 11-bit literal
    assign jump_tgt_w = {pc_upper_latch_r[bmam_pkg::LATCH_W-1 -: 2],
                         pc_lit_in};

    always_comb
    begin
        pc_nxt = pc_r;
        branch_w = 1'b0;
        push_w = 1'b0;
        pop_w = 1'b0;
        if (cyc_end_r)
        begin
            if (irq_take_in)
            begin
                pc_nxt = bmam_pkg::PC_IRQ_VEC;
                push_w = 1'b1;
                branch_w = 1'b1;
            end
            else if (pcl_go_w)
            begin
                pc_nxt = {pc_upper_latch_r, pcl_low_w};
                branch_w = 1'b1;
            end
            else
            begin
                unique case (pc_op_in)
                    bmam_pkg::BMAM_PC_SEQ:
                        pc_nxt = pc_r + bmam_pkg::PC_STEP;
                    bmam_pkg::BMAM_PC_GOTO:
                    begin
                        pc_nxt = jump_tgt_w;
                        branch_w = 1'b1;
                    end
                    bmam_pkg::BMAM_PC_CALL:
                    begin
                        pc_nxt = jump_tgt_w;
                        push_w = 1'b1;
                        branch_w = 1'b1;
                    end
                    bmam_pkg::BMAM_PC_RET:
                    begin
                        pc_nxt = stk_top_w;
                        pop_w = 1'b1;
                        branch_w = 1'b1;
                    end
                endcase
            end
        end
    end

    bmam_ret_stack u_stack (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .push_in(push_w),
        .pop_in(pop_w),
        .push_data_in(pc_r),
        .top_out(stk_top_w)
    );

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            pc_r <= bmam_pkg::PC_RESET_VEC;
            prog_addr_r <= bmam_pkg::PC_RESET_VEC[PROG_AW-1:0];
        end
        else
        begin
            pc_r <= pc_nxt;
            prog_addr_r <= pc_nxt[PROG_AW-1:0];
        end
    end

    // branch flushes prefetch
    // the word fetched behind a branch is stale, so the core runs a nop
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            instr_r <= '0;
            flush_r <= 1'b1;
        end
        else if (cyc_end_r)
        begin
            instr_r <= prog_word_in;
            flush_r <= branch_w;
        end
    end

    assign prog_addr_out = prog_addr_r;
    assign pc_out = pc_r;
    assign instr_out = instr_r;
    assign instr_flush_out = flush_r;
    assign cyc_end_out = cyc_end_r;
    assign dat_rdata_out = rdata_r;
    assign dat_rvalid_out = rvalid_r;
    assign status_out = status_r;
    assign intctl_out = intctl_r;

    sequence s_icyc_gap;
        !cyc_end_r [*3] ##1 cyc_end_r;
    endsequence

    sequence s_read_two;
        ##2 dat_rvalid_out && dat_rdata_out == 8'h00;
    endsequence

    AST_RESET_VEC: assert property (
        $rose(rst_n_in) |-> pc_r == bmam_pkg::PC_RESET_VEC)
        else $error("pc not at reset vector after reset");

    AST_IRQ_VEC: assert property (
        cyc_end_r && irq_take_in
            |=> pc_r == bmam_pkg::PC_IRQ_VEC && instr_flush_out)
        else $error("interrupt did not vector to 0004h");

    AST_PROG_WRAP: assert property (
        cyc_end_r |=> prog_addr_out == pc_r[PROG_AW-1:0])
        else $error("program address does not wrap onto store");

    AST_ICYC_LEN: assert property (
        cyc_end_r |=> s_icyc_gap)
        else $error("instruction cycle is not four clocks");

    AST_SEQ_NO_FLUSH: assert property (
        cyc_end_r && !irq_take_in && !pcl_go_w
            && pc_op_in == bmam_pkg::BMAM_PC_SEQ
            |=> !instr_flush_out && pc_r == $past(pc_r) + bmam_pkg::PC_STEP)
        else $error("plain instruction took extra cycle");

    AST_BANK_SEL: assert property (
        !ind_w |-> eff_addr_w[8:7] == status_r[6:5])
        else $error("direct bank does not follow status bits");

    AST_IND_ADDR: assert property (
        ind_w |-> eff_addr_w == {status_r[7], indirect_address_pointer_r})
        else $error("indirect address not formed from pointer");

    AST_UNIMPL_ZERO: assert property (
        dat_rd_in && !ram_hit_w && eff_off_w != bmam_pkg::OFF_PCL
            && !sel_status_w && !sel_pointer_w && !sel_latch_w
            && !sel_intctl_w |-> s_read_two)
        else $error("unimplemented location did not read zero");

    AST_MIRROR_STATUS: assert property (
        dat_rd_in && sel_status_w
            |-> ##2 dat_rdata_out == $past(status_r, 2))
        else $error("status not readable from this bank");

    AST_LATCH_LOAD: assert property (
        cyc_end_r && pcl_go_w && !irq_take_in
            |=> pc_r[12:8] == $past(pc_upper_latch_r))
        else $error("pc upper bits not loaded from latch");
endmodule // bmam_top

/* File: bench/bmam_prog_model.sv */
`timescale 1ns/1ps
// program store facing the core; each word carries its own address
module bmam_prog_model (
    input wire logic [10:0] addr_in,
    output logic [13:0] word_out
);
    assign word_out = {3'h5, addr_in};
endmodule // bmam_prog_model

/* File: bench/tb_banked_memory_address_map.sv */
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("mismatch %s exp %0h got %0h", what, exp, got); \
        end \
    end
module tb_banked_memory_address_map;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [13:0] prog_word;
    bmam_pkg::bmam_pcop_t pc_op = bmam_pkg::BMAM_PC_SEQ;
    logic [10:0] pc_lit = 11'h000;
    logic irq_take = 1'b0;
    logic [6:0] dat_addr = 7'h00;
    logic dat_rd = 1'b0;
    logic dat_wr = 1'b0;
    logic [7:0] dat_wdata = 8'h00;
    logic [10:0] prog_addr_out;
    logic [12:0] pc_out;
    logic [13:0] instr_out;
    logic instr_flush_out;
    logic cyc_end_out;
    logic dat_rvalid_out;
    logic [7:0] dat_rdata_out;
    logic [7:0] status_out;
    logic [7:0] intctl_out;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [12:0] stk [0:8];

    initial
    begin
        forever #25 mclk_in = ~mclk_in;
    end

    bmam_top #(.PROG_AW(11)) bmam_top_i (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .prog_word_in(prog_word),
        .pc_op_in(pc_op), .pc_lit_in(pc_lit), .irq_take_in(irq_take),
        .dat_addr_in(dat_addr), .dat_rd_in(dat_rd), .dat_wr_in(dat_wr),
        .dat_wdata_in(dat_wdata), .prog_addr_out(prog_addr_out),
        .pc_out(pc_out), .instr_out(instr_out),
        .instr_flush_out(instr_flush_out), .cyc_end_out(cyc_end_out),
        .dat_rdata_out(dat_rdata_out), .dat_rvalid_out(dat_rvalid_out),
        .status_out(status_out), .intctl_out(intctl_out)
    );

    bmam_prog_model bmam_prog_model_i (
        .addr_in(prog_addr_out),
        .word_out(prog_word)
    );

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // op is held only over the cycle whose end takes it
    task automatic issue(input bmam_pkg::bmam_pcop_t op,
                         input logic [10:0] lit, input logic irq);
        int k;
        @(posedge mclk_in);
        pc_op <= op;
        pc_lit <= lit;
        irq_take <= irq;
        k = 0;
        @(negedge mclk_in);
        while (cyc_end_out !== 1'b1 && k < 8)
        begin
            @(negedge mclk_in);
            k++;
        end
        `CHK("cycle end seen", 1, int'(k < 8));
        @(posedge mclk_in);
        pc_op <= bmam_pkg::BMAM_PC_SEQ;
        irq_take <= 1'b0;
        @(negedge mclk_in);
    endtask

    task automatic dwrite(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        dat_addr <= a;
        dat_wdata <= d;
        dat_wr <= 1'b1;
        @(posedge mclk_in);
        dat_wr <= 1'b0;
        @(negedge mclk_in);
    endtask

    // answer lands exactly one edge after the taking edge
    task automatic dread(input logic [6:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        dat_addr <= a;
        dat_rd <= 1'b1;
        @(posedge mclk_in);
        dat_rd <= 1'b0;
        @(posedge mclk_in);
        @(negedge mclk_in);
        `CHK("rvalid", 1'b1, dat_rvalid_out);
        `CHK("rdata", exp, dat_rdata_out);
    endtask

    task automatic bank(input logic [1:0] b, input logic indirect_bank_select);
        dwrite(7'h03, {indirect_bank_select, b, 5'h18});
        `CHK("bank bits", {indirect_bank_select, b}, status_out[7:5]);
    endtask

    task automatic t_seq;
        int n;
        logic [12:0] p;
        p = pc_out;
        issue(bmam_pkg::BMAM_PC_SEQ, 11'h000, 1'b0);
        `CHK("pc after first step", 13'h0001, pc_out);
        `CHK("instr at vector", {3'h5, 11'h000}, instr_out);
        `CHK("flush", 1'b0, instr_flush_out);
        n = 1;
        @(negedge mclk_in);
        while (cyc_end_out !== 1'b1 && n < 9)
        begin
            @(negedge mclk_in);
            n++;
        end
        n = 0;
        do
        begin
            @(negedge mclk_in);
            n++;
        end
        while (cyc_end_out !== 1'b1 && n < 9);
        `CHK("clocks per cycle", 4, n);
        $display("test seq done");
    endtask

    task automatic t_goto_wrap;
        dwrite(7'h0A, 8'h08);
        issue(bmam_pkg::BMAM_PC_GOTO, 11'h123, 1'b0);
        `CHK("goto pc", 13'h0923, pc_out);
        `CHK("wrapped fetch", 11'h123, prog_addr_out);
        `CHK("flush after goto", 1'b1, instr_flush_out);
        issue(bmam_pkg::BMAM_PC_SEQ, 11'h000, 1'b0);
        `CHK("pc step", 13'h0924, pc_out);
        `CHK("wrapped word", {3'h5, 11'h123}, instr_out);
        `CHK("flush cleared", 1'b0, instr_flush_out);
        dwrite(7'h02, 8'h34);
        issue(bmam_pkg::BMAM_PC_SEQ, 11'h000, 1'b0);
        `CHK("pc low write", 13'h0834, pc_out);
        `CHK("flush on pc write", 1'b1, instr_flush_out);
        issue(bmam_pkg::BMAM_PC_SEQ, 11'h000, 1'b0);
        dwrite(7'h0A, 8'h00);
        $display("test goto wrap done");
    endtask

    task automatic t_stack;
        for (int i = 0; i < 9; i++)
        begin
            stk[i] = pc_out;
            issue(bmam_pkg::BMAM_PC_CALL, 11'(64 + 32 * i), 1'b0);
            `CHK("call pc", 13'(64 + 32 * i), pc_out);
            issue(bmam_pkg::BMAM_PC_SEQ, 11'h000, 1'b0);
        end
        // ninth push has overwritten the oldest one
        for (int j = 8; j > 0; j--)
        begin
            issue(bmam_pkg::BMAM_PC_RET, 11'h000, 1'b0);
            `CHK("return pc", stk[j], pc_out);
            issue(bmam_pkg::BMAM_PC_SEQ, 11'h000, 1'b0);
        end
        stk[0] = pc_out;
        issue(bmam_pkg::BMAM_PC_GOTO, 11'h200, 1'b1);
        `CHK("irq vector", 13'h0004, pc_out);
        issue(bmam_pkg::BMAM_PC_SEQ, 11'h000, 1'b0);
        issue(bmam_pkg::BMAM_PC_RET, 11'h000, 1'b0);
        `CHK("irq return", stk[0], pc_out);
        $display("test stack done");
    endtask

    task automatic t_banks;
        dwrite(7'h04, 8'h5A);
        for (int b = 0; b < 4; b++)
        begin
            bank(2'(b), 1'b0);
            dwrite(7'h20, 8'(8'hA0 + b));
        end
        for (int b = 0; b < 4; b++)
        begin
            bank(2'(b), 1'b0);
            dread(7'h20, (b == 3) ? 8'h00 : 8'(8'hA0 + b));
            dread(7'h04, 8'h5A);
        end
        bank(2'h1, 1'b0);
        dwrite(7'h70, 8'hC3);
        dwrite(7'h01, 8'hFF);
        dread(7'h01, 8'h00);
        bank(2'h2, 1'b0);
        dread(7'h70, 8'hC3);
        dwrite(7'h0B, 8'h5A);
        `CHK("intctl", 8'h5A, intctl_out);
        dwrite(7'h0B, 8'h00);
        $display("test banks done");
    endtask

    task automatic t_indirect;
        bank(2'h0, 1'b0);
        dwrite(7'h04, 8'hA0);
        dread(7'h00, 8'hA1);
        dwrite(7'h00, 8'h77);
        bank(2'h1, 1'b0);
        dread(7'h20, 8'h77);
        bank(2'h0, 1'b1);
        dwrite(7'h04, 8'h20);
        dread(7'h00, 8'hA2);
        dwrite(7'h04, 8'h80);
        dread(7'h00, 8'h00);
        dwrite(7'h04, 8'h00);
        dwrite(7'h00, 8'h11);
        dread(7'h00, 8'h00);
        $display("test indirect done");
    endtask

    initial
    begin
        #(50 * 6000);
        n_mismatch++;
        $display("watchdog expired");
        give_verdict();
    end

    initial
    begin
        repeat (6) @(posedge mclk_in);
        @(negedge mclk_in);
        `CHK("reset pc", 13'h0000, pc_out);
        `CHK("reset status", 8'h18, status_out);
        `CHK("reset intctl", 8'h00, intctl_out);
        `CHK("reset flush", 1'b1, instr_flush_out);
        @(posedge mclk_in);
        rst_n_in <= 1'b1;
        $display("test reset done");
        t_seq();
        t_goto_wrap();
        t_stack();
        t_banks();
        t_indirect();
        give_verdict();
    end
endmodule // tb_banked_memory_address_map
